/* File: ssr_supervisor.sv */
// Supply supervisor reset: supply hold timer and manual one-shot.
// Assumes inputs synchronous to clock; the manual pin pull-up is resolved here from the enable.
`timescale 1ns/1ps
`default_nettype none
module ssr_supervisor #(
  parameter bit LONG_TIMEOUT_OPTION = 1'b0,
  parameter bit OPEN_DRAIN          = 1'b0,
  parameter int unsigned SHORT_CYC  = ssr_pkg::SHORT_TIMEOUT_CYC,
  parameter int unsigned LONG_CYC   = ssr_pkg::LONG_TIMEOUT_CYC,
  parameter int unsigned PULSE_CYC  = ssr_pkg::MANUAL_PULSE_CYC,
  parameter int unsigned DEBNC_CYC  = ssr_pkg::DEBOUNCE_CYC
) (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       supply_below,
  input  wire logic [1:0] dip_depth,
  input  wire logic       manual_reset_n,
  input  wire logic       manual_reset_n_oe,
  output var  logic       reset_n_o,
  output var  logic       reset_n_oe,
  output var  logic       supply_hold,
  output var  logic       manual_active
);

  localparam int unsigned W = ssr_pkg::CNT_W;

  function automatic logic [W-1:0] ssr_dec(input logic [W-1:0] v);
    ssr_dec = (v == '0) ? '0 : v - W'(1);
  endfunction

  logic           supply_low;
  logic [W-1:0]   sup_cnt_q;
  logic           sup_hold_q;
  logic [W-1:0]   man_cnt_q;
  ssr_pkg::ssr_man_t man_q;
  logic           man_in_q;
  logic           man_level;
  logic           fall;
  logic           reset_low;

  // ==========================================================
  // Supply qualification
  ssr_glitch_filter u_filt (
    .clock        (clock),
    .arst_n       (arst_n),
    .clk_en       (clk_en),
    .supply_below (supply_below),
    .dip_depth    (dip_depth),
    .supply_low   (supply_low)
  );

  // ==========================================================
  // Supply hold timer
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      sup_cnt_q  <= '0;
      sup_hold_q <= 1'b1;
    end else if (clk_en) begin
      if (supply_low) begin
        sup_hold_q <= 1'b1;
        sup_cnt_q  <= LONG_TIMEOUT_OPTION ? W'(LONG_CYC)
                                          : W'(SHORT_CYC);
      end else if (sup_cnt_q > W'(1)) begin
        sup_cnt_q  <= ssr_dec(sup_cnt_q);
      end else begin
        sup_cnt_q  <= '0;
        sup_hold_q <= 1'b0;
      end
    end
  end

  // ==========================================================
  // Manual input edge detection; undriven pin reads high
  assign man_level = manual_reset_n_oe ? manual_reset_n : 1'b1;
  assign fall      = man_in_q && !man_level;

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      man_in_q <= 1'b1;
    end else if (clk_en) begin
      man_in_q <= man_level;
    end
  end

  // ==========================================================
  // Manual one-shot
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      man_q     <= ssr_pkg::SSR_ARMED;
      man_cnt_q <= '0;
    end else if (clk_en) begin
      case (man_q)
        ssr_pkg::SSR_ARMED: begin
          if (fall) begin
            man_q     <= ssr_pkg::SSR_PULSE;
            man_cnt_q <= W'(PULSE_CYC);
          end
        end
        ssr_pkg::SSR_PULSE: begin
          if (man_cnt_q > W'(1)) begin
            man_cnt_q <= ssr_dec(man_cnt_q);
          end else if (man_level) begin
            man_q     <= ssr_pkg::SSR_DEBNC;
            man_cnt_q <= W'(DEBNC_CYC);
          end else begin
            man_q     <= ssr_pkg::SSR_WAITHI;
            man_cnt_q <= '0;
          end
        end
        ssr_pkg::SSR_WAITHI: begin
          if (man_level) begin
            man_q     <= ssr_pkg::SSR_DEBNC;
            man_cnt_q <= W'(DEBNC_CYC);
          end
        end
        ssr_pkg::SSR_DEBNC: begin
          if (!man_level) begin
            man_q     <= ssr_pkg::SSR_WAITHI;
            man_cnt_q <= '0;
          end else if (man_cnt_q > W'(1)) begin
            man_cnt_q <= ssr_dec(man_cnt_q);
          end else begin
            man_q     <= ssr_pkg::SSR_ARMED;
            man_cnt_q <= '0;
          end
        end
        default: begin
          man_q     <= ssr_pkg::SSR_ARMED;
          man_cnt_q <= '0;
        end
      endcase
    end
  end

  // ==========================================================
  // Output combine and drive style
  assign reset_low = supply_low || sup_hold_q ||
                     (man_q == ssr_pkg::SSR_PULSE);

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      reset_n_o     <= 1'b0;
      reset_n_oe    <= 1'b1;
      supply_hold   <= 1'b1;
      manual_active <= 1'b0;
    end else if (clk_en) begin
      reset_n_o     <= !reset_low;
      reset_n_oe    <= OPEN_DRAIN ? reset_low : 1'b1;
      supply_hold   <= supply_low || sup_hold_q;
      manual_active <= (man_q == ssr_pkg::SSR_PULSE);
    end
  end

endmodule
`default_nettype wire

/* File: ssr_pkg.sv */
// Constants and types for the supply supervisor reset block.
// Assumes a 25 MHz clock; no bus, all options are parameters.
// Operation
// - Reset output is low while the qualified supply is below threshold.
// - After supply recovery the reset stays low for the supply timeout.
// - A manual input falling edge gives one fixed-length reset pulse.
// - Only the first falling edge acts; later ones in pulse or debounce don't.
// - The one-shot re-arms only after the input is high for the debounce.
// - Supply timeout is short (150-300 ms) or long (1200-2400 ms).
// - Manual pulse and debounce each last 150-300 ms for both options.
// - An unconnected manual input reads high and never triggers a reset.
// - The reset output is open-drain or push-pull by option.
// - Short supply dips are filtered, less so the deeper they go.
package ssr_pkg;

  // ==========================================================
  // Timing
  localparam int unsigned CLK_HZ           = 25_000_000;
  localparam int unsigned SHORT_TIMEOUT_MS = 150;
  localparam int unsigned LONG_TIMEOUT_MS  = 1200;
  localparam int unsigned MANUAL_PULSE_MS  = 150;
  localparam int unsigned DEBOUNCE_MS      = 150;
  localparam int unsigned CYC_PER_MS       = CLK_HZ / 1000;
  localparam int unsigned SHORT_TIMEOUT_CYC = SHORT_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned LONG_TIMEOUT_CYC  = LONG_TIMEOUT_MS * CYC_PER_MS;
  localparam int unsigned MANUAL_PULSE_CYC  = MANUAL_PULSE_MS * CYC_PER_MS;
  localparam int unsigned DEBOUNCE_CYC      = DEBOUNCE_MS * CYC_PER_MS;

  // ==========================================================
  // Glitch filter limit on weighted dip time; counter widths
  localparam int unsigned GLITCH_LIMIT    = 2500;
  localparam int unsigned CNT_W           = 32;
  localparam int unsigned FILT_W          = 16;

  // ==========================================================
  // Manual one-shot states
  typedef enum logic [1:0] {
    SSR_ARMED  = 2'b00,
    SSR_PULSE  = 2'b01,
    SSR_WAITHI = 2'b11,
    SSR_DEBNC  = 2'b10
  } ssr_man_t;

endpackage

/* File: ssr_glitch_filter.sv */
// Supply dip filter: integrates depth-weighted below-threshold time.
// Assumes below and depth inputs are synchronous to clock.
`timescale 1ns/1ps
`default_nettype none
module ssr_glitch_filter (
  input  wire logic       clock,
  input  wire logic       arst_n,
  input  wire logic       clk_en,
  input  wire logic       supply_below,
  input  wire logic [1:0] dip_depth,
  output var  logic       supply_low
);

  logic [ssr_pkg::FILT_W-1:0] acc_q;
  logic [ssr_pkg::FILT_W-1:0] acc_d;
  logic [ssr_pkg::FILT_W-1:0] step;

  // ==========================================================
  // Deeper dips charge faster
  always_comb begin
    step  = ssr_pkg::FILT_W'(1) << dip_depth;
    acc_d = acc_q;
    if (!supply_below) begin
      acc_d = '0;
    end else if (acc_q < ssr_pkg::FILT_W'(ssr_pkg::GLITCH_LIMIT)) begin
      acc_d = acc_q + step;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      acc_q <= '0;
    end else if (clk_en) begin
      acc_q <= acc_d;
    end
  end

  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      supply_low <= 1'b1;
    end else if (clk_en) begin
      supply_low <= supply_below &&
        (acc_d >= ssr_pkg::FILT_W'(ssr_pkg::GLITCH_LIMIT));
    end
  end

endmodule
`default_nettype wire

/* File: ssr_button.sv */
// Manual reset source model: pushbutton to ground.
// Assumes the block resolves the pin pull-up from the enable.
`timescale 1ns/1ps
`default_nettype none
module ssr_button (
  input  wire logic press,
  output var  logic pin_n,
  output var  logic pin_oe
);
  // ==========================================
  // Pin pulled low only while pressed
  always_comb begin
    pin_oe = press;
    pin_n  = !press;
  end
endmodule
`default_nettype wire

/* File: ssr_supervisor_assertions.sv */
// Checker for the supervisor reset ports.
// Assumes bound to the top module with small cycle counts.
`timescale 1ns/1ps
`default_nettype none
module ssr_supervisor_assertions #(
  parameter bit          OPEN_DRAIN = 1'b0,
  parameter int unsigned PULSE_CYC  = 10
) (
  input wire logic       clock,
  input wire logic       arst_n,
  input wire logic       clk_en,
  input wire logic       supply_below,
  input wire logic [1:0] dip_depth,
  input wire logic       manual_reset_n,
  input wire logic       manual_reset_n_oe,
  input wire logic       reset_n_o,
  input wire logic       reset_n_oe,
  input wire logic       supply_hold,
  input wire logic       manual_active
);
  localparam int PLO = PULSE_CYC - 1;
  localparam int PHI = PULSE_CYC + 1;
  localparam logic [15:0] QUAL = 16'(ssr_pkg::GLITCH_LIMIT + 16);
  wire logic        pin_lo = manual_reset_n_oe & !manual_reset_n;
  logic      [15:0] lvl_q;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  // ==========================================
  // Weighted dip time, cleared on recovery
  always_ff @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      lvl_q <= 16'h0000;
    end else if (clk_en) begin
      if (!supply_below) begin
        lvl_q <= 16'h0000;
      end else if (lvl_q < 16'h7fff) begin
        lvl_q <= lvl_q + (16'h0001 << dip_depth);
      end
    end
  end
  // ==========================================
  // Assertions
  or_out_a: assert property (
    reset_n_o == !(supply_hold || manual_active))
    else $error("reset output not the or of its causes");
  oe_mode_a: assert property (
    reset_n_oe == (!OPEN_DRAIN || !reset_n_o))
    else $error("reset enable wrong for output mode");
  hold_below_a: assert property (
    lvl_q >= QUAL |-> supply_hold)
    else $error("supply hold missing while supply low");
  timeout_run_a: assert property (
    $fell(supply_below) && lvl_q >= QUAL |-> supply_hold[*8])
    else $error("supply timeout cut short");
  fall_cause_a: assert property (
    $fell(supply_hold) |-> lvl_q < QUAL)
    else $error("supply hold ended while supply low");
  pulse_min_a: assert property (
    $rose(manual_active) |-> manual_active[*8])
    else $error("manual pulse too short");
  pulse_end_a: assert property (
    $rose(manual_active) |-> ##[PLO:PHI] !manual_active)
    else $error("manual pulse too long");
  fire_edge_a: assert property (
    $rose(manual_active) |-> $past(pin_lo, 2))
    else $error("manual pulse without low input");
  cover property ($rose(manual_active));
  cover property ($fell(supply_hold));
  cover property ($rose(supply_hold));
endmodule
bind ssr_supervisor ssr_supervisor_assertions #(
  .OPEN_DRAIN(OPEN_DRAIN), .PULSE_CYC(PULSE_CYC)
) i_ssr_supervisor_assertions (
  .clock(clock), .arst_n(arst_n), .clk_en(clk_en),
  .supply_below(supply_below), .dip_depth(dip_depth),
  .manual_reset_n(manual_reset_n), .manual_reset_n_oe(manual_reset_n_oe),
  .reset_n_o(reset_n_o), .reset_n_oe(reset_n_oe),
  .supply_hold(supply_hold), .manual_active(manual_active)
);
`default_nettype wire

/* File: ssr_supervisor_tb.sv */
// Testbench for the supervisor reset block with a button model.
// Assumes small counts: short timeout 20, long timeout 40, pulse 10, debounce 10.
`timescale 1ns/1ps
`default_nettype none
module ssr_supervisor_tb;
  logic       clock = 1'b0;
  logic       arst_n = 1'b0;
  logic       below = 1'b0;
  logic       press = 1'b0;
  logic [1:0] depth = 2'h0;
  logic       pin_n, pin_oe, rst_n, rst_oe, hold, man;
  logic       en = 1'b1;
  logic       od_o, od_oe, od_man;
  wire logic  od_line;
  int         miscompares = 0;
  int         comparisons = 0;
  int         w, k;
  always #20 clock = !clock;
  ssr_button i_ssr_button (.press(press), .pin_n(pin_n), .pin_oe(pin_oe));
  ssr_supervisor #(.SHORT_CYC(20), .LONG_CYC(40), .PULSE_CYC(10),
    .DEBNC_CYC(10)) i_ssr_supervisor (.clock(clock), .arst_n(arst_n),
    .clk_en(en), .supply_below(below), .dip_depth(depth),
    .manual_reset_n(pin_n), .manual_reset_n_oe(pin_oe), .reset_n_o(rst_n),
    .reset_n_oe(rst_oe), .supply_hold(hold), .manual_active(man));
  ssr_supervisor #(.LONG_TIMEOUT_OPTION(1'b1), .OPEN_DRAIN(1'b1),
    .SHORT_CYC(20), .LONG_CYC(40), .PULSE_CYC(10), .DEBNC_CYC(10))
    i_ssr_supervisor_od (.clock(clock), .arst_n(arst_n), .clk_en(en),
    .supply_below(below), .dip_depth(depth), .manual_reset_n(pin_n),
    .manual_reset_n_oe(pin_oe), .reset_n_o(od_o), .reset_n_oe(od_oe),
    .supply_hold(), .manual_active(od_man));
  // Pull-up on the open-drain reset line
  assign od_line = od_oe ? od_o : 1'b1;
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic chk(input string s, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("mismatch %s expected %b seen %b", s, e, g);
    end
  endtask
  task automatic wait_low(output int n);
    for (n = 0; rst_n !== 1'b0 && n < 400; n++) cyc(1);
  endtask
  task automatic count_low(output int n);
    for (n = 0; rst_n === 1'b0 && n < 400; n++) cyc(1);
  endtask
  task automatic end_of_test();
    if (miscompares == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask
  // ==========================================
  // Scenarios
  task automatic t_dips();
    for (int d = 0; d < 3; d++) begin
      depth = d[1:0];
      below = 1'b1;
      cyc(300);
      chk("shallow dip", 1'b1, rst_n);
      below = 1'b0;
      cyc(20);
    end
    chk("idle button", 1'b1, rst_n);
    chk("push-pull enable", 1'b1, rst_oe);
    chk("od released", 1'b1, od_line);
    chk("od enable off", 1'b0, od_oe);
  endtask
  task automatic t_freeze();
    en = 1'b0;
    depth = 2'h3;
    below = 1'b1;
    cyc(400);
    chk("frozen", 1'b1, rst_n);
    below = 1'b0;
    en = 1'b1;
    cyc(2);
    chk("resumed", 1'b1, rst_n);
  endtask
  task automatic t_supply();
    depth = 2'h3;
    below = 1'b1;
    wait_low(w);
    chk("deep dip", 1'b1, w > 250 && w <= 330);
    cyc(50);
    chk("held low", 1'b0, rst_n);
    chk("hold flag", 1'b1, hold);
    below = 1'b0;
    count_low(k);
    chk("timeout", 1'b1, k >= 20 && k <= 24);
    chk("hold flag end", 1'b0, hold);
    chk("long timeout", 1'b0, od_line);
    cyc(19);
    chk("long held", 1'b0, od_line);
    chk("od drives low", 1'b1, od_oe);
    cyc(2);
    chk("long release", 1'b1, od_line);
    chk("od floats", 1'b0, od_oe);
  endtask
  task automatic t_manual();
    for (int r = 0; r < 2; r++) begin
      press = 1'b1;
      wait_low(w);
      chk("edge fires", 1'b1, w <= 3);
      chk("manual flag", 1'b1, man);
      chk("od pulse", 1'b1, od_man);
      count_low(k);
      chk("pulse length", 1'b1, k == 10);
      chk("manual flag end", 1'b0, man);
      cyc(20);
      chk("held input", 1'b1, rst_n);
      press = 1'b0;
      cyc(4);
      press = 1'b1;
      cyc(15);
      chk("bounce ignored", 1'b1, rst_n);
      press = 1'b0;
      cyc(8);
      press = 1'b1;
      cyc(15);
      chk("debounce restart", 1'b1, rst_n);
      press = 1'b0;
      cyc(14);
    end
  endtask
  initial begin
    cyc(6000);
    miscompares++;
    end_of_test();
  end
  initial begin
    cyc(20);
    arst_n = 1'b1;
    count_low(k);
    chk("power timeout", 1'b1, k >= 20 && k <= 24);
    t_dips();
    t_freeze();
    t_supply();
    t_manual();
    end_of_test();
  end
endmodule
`default_nettype wire
